// ### sib_cpu_model.sv
// partner model: reset pin wire with pull-up, cpu side counting vector events
// assumes: rstPinOut/rstPinOe from the core, extLow from the bench
`timescale 1ns/1ps
`default_nettype none
module sib_cpu_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        rstPinOe,
    input  wire logic        rstPinOut,
    input  wire logic        extLow,
    input  wire logic        forceSwi,
    input  wire logic        stackStart,
    output logic             rstPinIn,
    output logic [7:0]       swiCount,
    output logic [7:0]       stackCount
);
    // wired pin: pull-up unless the core or an outside party pulls low
    assign rstPinIn = !((rstPinOe && !rstPinOut) || extLow);

    // cpu side only counts vector fetches and stacking starts
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            swiCount   <= 8'h00;
            stackCount <= 8'h00;
        end else begin
            swiCount   <= swiCount + {7'h00, forceSwi};
            stackCount <= stackCount + {7'h00, stackStart};
        end
    end
endmodule
`default_nettype wire

// ### sib_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the system integration core only
`ifndef SIB_DEFS_SVH
`define SIB_DEFS_SVH
`define SIB_ADDR_BRK_STATUS   16'hfe00
`define SIB_ADDR_RST_SOURCE   16'hfe01
`define SIB_ADDR_BRK_FLAG_CTL 16'hfe03
`define SIB_BIT_BRK_WAIT_EXIT 1
`define SIB_BIT_BRK_CLR_EN    7
`define SIB_BIT_POR           7
`define SIB_BIT_PIN           6
`define SIB_BIT_WDOG          5
`define SIB_BIT_BAD_OPCODE    4
`define SIB_BIT_BAD_ADDR      3
`define SIB_BIT_MONITOR       2
`define SIB_BIT_LOW_VOLT      1
`define SIB_RST_SOURCE_POR    8'h80
`define SIB_STOP_LONG_CYC     4096
`define SIB_STOP_SHORT_CYC    32
`define SIB_PIN_SAMPLE_CYC    32
`define SIB_RST_HOLD_CYC      32
`endif

// ### sib_pkg.sv
// types shared by the system integration core
// assumes: nothing beyond a SystemVerilog compiler
package sib_pkg;
    typedef enum logic [2:0] {
        SIB_RESET   = 3'b000,
        SIB_PINCHK  = 3'b001,
        SIB_RUN     = 3'b010,
        SIB_WAIT    = 3'b011,
        SIB_STOP    = 3'b100,
        SIB_RECOVER = 3'b101
    } sib_state_e;
    typedef logic [7:0]  sib_byte_t;
    typedef logic [15:0] sib_addr_t;
endpackage

// ### sib_sys_integration.sv
// system integration core: reset sequencing, break steering, flag
// protection in break, wait/stop sequencing with stop recovery counter
// assumes: one bus clock; crystal clock counted one per core_clk cycle
//
// The strobed register port was left to the implementer.
`include "sib_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sib_sys_integration #(
    parameter int STOP_LONG_CYC  = `SIB_STOP_LONG_CYC,
    parameter int STOP_SHORT_CYC = `SIB_STOP_SHORT_CYC,
    parameter int PIN_SAMPLE_CYC = `SIB_PIN_SAMPLE_CYC,
    parameter int RST_HOLD_CYC   = `SIB_RST_HOLD_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          reset,
    input  wire sib_pkg::sib_addr_t regAddr,
    input  wire sib_pkg::sib_byte_t regWrData,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output sib_pkg::sib_byte_t regRdData,
    input  wire logic          rstPinIn,
    output logic               rstPinOut,
    output logic               rstPinOe,
    input  wire logic          watchdogTimeout,
    input  wire logic          badOpcode,
    input  wire logic          opcodeFetch,
    input  wire logic          unmappedAccess,
    input  wire logic          monitorEntry,
    input  wire logic          vectorsErased,
    input  wire logic          irqPinHigh,
    input  wire logic          lowVoltage,
    input  wire logic          watchdogDisable,
    input  wire logic          shortStopRecovery,
    input  wire logic          oscRunInStop,
    input  wire logic          waitInstr,
    input  wire logic          stopInstr,
    input  wire logic          irqReq,
    input  wire logic          breakReq,
    input  wire logic          breakDone,
    output logic               cpuReset,
    output logic               cpuClkEn,
    output logic               periphClkEn,
    output logic               crystalClkEn,
    output logic               clearIMask,
    output logic               forceSwi,
    output logic               stackStart,
    output logic               inBreak,
    output logic               flagClearAllow,
    output logic               watchdogEnable,
    output logic               watchdogTick
);
    import sib_pkg::*;

    sib_state_e state;
    logic [11:0] cnt;
    logic        breakClearEnable;
    logic        breakWaitExit;
    sib_byte_t   rstFlags;
    sib_byte_t   srcVec;
    logic        anySrc;
    logic        extSrc;
    logic        monSrc;
    logic        rdHit;
    logic [11:0] recLast;

    function automatic logic addrIs(input sib_addr_t a, input sib_addr_t b);
        return a == b;
    endfunction

    // reset sources; the pin is ignored while we drive it and through the pin check
    assign extSrc = !rstPinIn && state != SIB_RESET && state != SIB_PINCHK;
    assign monSrc = monitorEntry && vectorsErased && irqPinHigh;
    always_comb begin
        srcVec = 8'h00;
        srcVec[`SIB_BIT_PIN]        = extSrc;
        srcVec[`SIB_BIT_WDOG]       = watchdogTimeout;
        srcVec[`SIB_BIT_BAD_OPCODE] = badOpcode;
        srcVec[`SIB_BIT_BAD_ADDR]   = opcodeFetch && unmappedAccess;
        srcVec[`SIB_BIT_MONITOR]    = monSrc;
        srcVec[`SIB_BIT_LOW_VOLT]   = lowVoltage;
    end
    // any source at all wins over sequencing, steering pulses and break state, none ranked over another
    assign anySrc = |srcVec;

    // recovery end point follows the option live on every recovery cycle
    assign recLast = shortStopRecovery ? 12'(STOP_SHORT_CYC - 1)
                                       : 12'(STOP_LONG_CYC - 1);

    // sequencer; the shared counter also acts as the prescaler
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= SIB_RESET;
            cnt   <= 12'h000;
        end else if (anySrc) begin
            state <= SIB_RESET;
            cnt   <= 12'h000;
        end else begin
            cnt <= cnt + 12'h001;
            case (state)
                SIB_RESET: begin
                    if (cnt == 12'(RST_HOLD_CYC - 1)) begin
                        state <= SIB_PINCHK;
                        cnt   <= 12'h000;
                    end
                end
                SIB_PINCHK: begin
                    if (cnt == 12'(PIN_SAMPLE_CYC - 1)) begin
                        state <= SIB_RUN;
                    end
                end
                SIB_RUN: begin
                    if (!breakReq && stopInstr) begin
                        state <= SIB_STOP;
                        cnt   <= 12'h000;
                    end else if (!breakReq && waitInstr) begin
                        state <= SIB_WAIT;
                    end
                end
                SIB_WAIT: begin
                    if (irqReq || breakReq) begin
                        state <= SIB_RUN;
                    end
                end
                SIB_STOP: begin
                    cnt <= 12'h000;
                    if (irqReq || breakReq) begin
                        state <= SIB_RECOVER;
                    end
                end
                SIB_RECOVER: begin
                    if (cnt == recLast) begin
                        state <= SIB_RUN;
                    end
                end
                default: begin
                    state <= SIB_RESET;
                end
            endcase
        end
    end

    // note of a break pending across stop recovery
    logic recBreak;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            recBreak <= 1'b0;
        end else if (state == SIB_STOP && breakReq) begin
            recBreak <= 1'b1;
        end else if (state != SIB_RECOVER) begin
            recBreak <= 1'b0;
        end
    end

    // exception steering pulses toward the CPU
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            forceSwi   <= 1'b0;
            stackStart <= 1'b0;
            clearIMask <= 1'b0;
        end else begin
            forceSwi   <= !anySrc && ((breakReq && (state == SIB_RUN || state == SIB_WAIT))
                          || (state == SIB_RECOVER && cnt == recLast && recBreak));
            stackStart <= !anySrc && ((state == SIB_WAIT && irqReq && !breakReq)
                          || (state == SIB_RECOVER && cnt == recLast && !recBreak));
            clearIMask <= !anySrc && state == SIB_RUN && !breakReq
                          && (waitInstr || stopInstr);
        end
    end

    // break state tracking, left by the CPU's return from the handler
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            inBreak <= 1'b0;
        end else if (anySrc) begin
            inBreak <= 1'b0;
        end else if (forceSwi) begin
            inBreak <= 1'b1;
        end else if (breakDone) begin
            inBreak <= 1'b0;
        end
    end

    // peripherals gate every clear step on this, so a first step taken
    // before break cannot complete inside it, and nothing restores a flag
    assign flagClearAllow = !inBreak || breakClearEnable;

    // clock gating and reset pin; pin is open drain, driven low only
    always_comb begin
        cpuReset     = state == SIB_RESET || state == SIB_PINCHK;
        cpuClkEn     = state == SIB_RUN || cpuReset;
        periphClkEn  = state != SIB_STOP && state != SIB_RECOVER;
        crystalClkEn = state != SIB_STOP || oscRunInStop;
        rstPinOut    = 1'b0;
        rstPinOe     = state == SIB_RESET;
        watchdogEnable = !watchdogDisable;
    end

    // prescaler overflow clocks the watchdog, also through wait mode
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            watchdogTick <= 1'b0;
        end else begin
            watchdogTick <= watchdogEnable && cnt == 12'hfff
                            && (state == SIB_RUN || state == SIB_WAIT);
        end
    end

    assign rdHit = regRd && addrIs(regAddr, `SIB_ADDR_RST_SOURCE);

    // reset source flags; a new source beats a clearing read
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rstFlags <= `SIB_RST_SOURCE_POR;
        end else begin
            rstFlags <= (rdHit ? 8'h00 : rstFlags) | srcVec;
            if (state == SIB_PINCHK && cnt == 12'(PIN_SAMPLE_CYC - 1) && !rstPinIn) begin
                rstFlags[`SIB_BIT_PIN] <= 1'b1;
            end
        end
    end

    // wait exit by break; software clears it by writing a zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            breakWaitExit <= 1'b0;
        end else if (state == SIB_WAIT && breakReq && !anySrc) begin
            breakWaitExit <= 1'b1;
        end else if (regWr && addrIs(regAddr, `SIB_ADDR_BRK_STATUS)
                     && !regWrData[`SIB_BIT_BRK_WAIT_EXIT]) begin
            breakWaitExit <= 1'b0;
        end
    end

    // break flag clear enable, off after reset so flags stay safe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            breakClearEnable <= 1'b0;
        end else if (regWr && addrIs(regAddr, `SIB_ADDR_BRK_FLAG_CTL)) begin
            breakClearEnable <= regWrData[`SIB_BIT_BRK_CLR_EN];
        end
    end

    // read port; data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else if (!regRd) begin
            regRdData <= 8'h00;
        end else if (addrIs(regAddr, `SIB_ADDR_BRK_STATUS)) begin
            regRdData <= {6'h00, breakWaitExit, 1'b0};
        end else if (rdHit) begin
            regRdData <= rstFlags;
        end else if (addrIs(regAddr, `SIB_ADDR_BRK_FLAG_CTL)) begin
            regRdData <= {breakClearEnable, 7'h00};
        end else begin
            regRdData <= 8'h00;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence shortStopExit;
        state == SIB_STOP && irqReq && !breakReq && shortStopRecovery && !anySrc;
    endsequence
    sequence shortRecovery;
        (state == SIB_RECOVER && !stackStart)[*8] ##24 state == SIB_RECOVER ##1 stackStart;
    endsequence

    any_src_reset_a: assert property (anySrc |=> state == SIB_RESET && cpuReset)
        else $error("reset source did not start reset");
    break_swi_a: assert property (breakReq && !anySrc && state == SIB_RUN |=> forceSwi)
        else $error("break did not force software interrupt");
    clr_protect_a: assert property (inBreak && !breakClearEnable |-> !flagClearAllow)
        else $error("flag clear allowed in protected break");
    imask_clear_a: assert property (state == SIB_RUN && waitInstr && !breakReq && !anySrc
                                    |=> clearIMask && state == SIB_WAIT)
        else $error("wait entry did not clear interrupt mask");
    wait_clocks_a: assert property (state == SIB_WAIT |-> !cpuClkEn && periphClkEn)
        else $error("wait mode clock gating wrong");
    wait_stack_a: assert property (state == SIB_WAIT && irqReq && !breakReq && !anySrc
                                   |=> stackStart && state == SIB_RUN)
        else $error("wait wakeup stacking not one cycle later");
    wait_break_a: assert property (state == SIB_WAIT && breakReq && !anySrc
                                   |=> breakWaitExit && forceSwi)
        else $error("break in wait did not set exit flag");
    stop_hold_a: assert property (state == SIB_STOP |=> cnt == 12'h000 || state == SIB_RESET)
        else $error("prescaler not held in stop");
    stop_clocks_a: assert property (state == SIB_STOP |-> !periphClkEn && !cpuClkEn)
        else $error("clocks running in stop");
    short_recover_a: assert property (shortStopExit |=> shortRecovery)
        else $error("short stop recovery length wrong");
    src_read_a: assert property (rdHit && !anySrc && state == SIB_RUN
                                 |=> regRdData == $past(rstFlags) && rstFlags == 8'h00)
        else $error("reset status read did not clear");
    pin_drive_a: assert property ($rose(state == SIB_PINCHK) |-> !rstPinOe ##0
                                  $past(rstPinOe))
        else $error("reset pin not driven through hold");
    // prescaler overflow in wait must still clock the watchdog when enabled
    wdog_en_a: assert property (state == SIB_WAIT && cnt == 12'hfff && !anySrc
                                |=> watchdogTick == !watchdogDisable)
        else $error("watchdog tick wrong in wait");

    // recovery hold, stop entry, option write and flag capture
    recover_hold_a: assert property (state == SIB_RECOVER |-> !stackStart && !forceSwi && !cpuClkEn)
        else $error("cpu released during stop recovery");
    recover_count_a: assert property (state == SIB_RECOVER && cnt != recLast && !anySrc
                                      |=> cnt == $past(cnt) + 12'h001)
        else $error("prescaler not counting in recovery");
    stop_entry_a: assert property (state == SIB_RUN && stopInstr && !breakReq && !anySrc
                                   |=> clearIMask && state == SIB_STOP && cnt == 12'h000)
        else $error("stop entry did not clear interrupt mask");
    clr_en_write_a: assert property (regWr && addrIs(regAddr, `SIB_ADDR_BRK_FLAG_CTL)
                                     && regWrData[`SIB_BIT_BRK_CLR_EN] |=> breakClearEnable)
        else $error("break clear enable write lost");
    src_flag_set_a: assert property (anySrc
                                     |=> (rstFlags & $past(srcVec)) == $past(srcVec))
        else $error("reset source flag not set");
    brk_exit_a: assert property (inBreak && breakDone && !forceSwi && !anySrc |=> !inBreak)
        else $error("break state not left");
    rd_idle_a: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data not idle");
endmodule
`default_nettype wire

// ### sib_sys_integration_tb.sv
// self-checking bench for the system integration core
// assumes: core and partner model compiled first; long stop count cut to 64
`timescale 1ns/1ps
`default_nettype none
module sib_sys_integration_tb;
    import sib_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, extLow = 1'b0;
    sib_addr_t regAddr = 16'h0000;
    sib_byte_t regWrData = 8'h00, regRdData;
    logic rstPinIn, rstPinOut, rstPinOe, cpuReset, cpuClkEn, periphClkEn, crystalClkEn;
    logic clearIMask, forceSwi, stackStart, inBreak, flagClearAllow, watchdogEnable, watchdogTick;
    logic watchdogTimeout = 1'b0, badOpcode = 1'b0, opcodeFetch = 1'b0, unmappedAccess = 1'b0;
    logic monitorEntry = 1'b0, vectorsErased = 1'b0, irqPinHigh = 1'b0, lowVoltage = 1'b0;
    logic watchdogDisable = 1'b0, shortStopRecovery = 1'b1, oscRunInStop = 1'b0, waitInstr = 1'b0;
    logic stopInstr = 1'b0, irqReq = 1'b0, breakReq = 1'b0, breakDone = 1'b0;
    logic [7:0] swiCount, stackCount;
    int failures = 0, check_count = 0;

    always #2 core_clk = ~core_clk;

    sib_sys_integration #(.STOP_LONG_CYC(64)) sib_sys_integration_inst (.core_clk, .reset, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData, .rstPinIn, .rstPinOut, .rstPinOe, .watchdogTimeout,
        .badOpcode, .opcodeFetch, .unmappedAccess, .monitorEntry, .vectorsErased, .irqPinHigh,
        .lowVoltage, .watchdogDisable, .shortStopRecovery, .oscRunInStop, .waitInstr, .stopInstr,
        .irqReq, .breakReq, .breakDone, .cpuReset, .cpuClkEn, .periphClkEn, .crystalClkEn,
        .clearIMask, .forceSwi, .stackStart, .inBreak, .flagClearAllow, .watchdogEnable, .watchdogTick);

    sib_cpu_model sib_cpu_model_inst (.core_clk, .reset, .rstPinOe, .rstPinOut, .extLow, .forceSwi,
        .stackStart, .rstPinIn, .swiCount, .stackCount);

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expd);
        check_count++;
        if (seen !== expd) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, expd, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic reg_write(input sib_addr_t a, input sib_byte_t d);
        @(posedge core_clk);
        regWr <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic reg_read(input sib_addr_t a, input sib_byte_t expd, input string name);
        @(posedge core_clk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 check(name, {8'h00, regRdData}, {8'h00, expd});
    endtask

    // bounded wait for the reset hold and pin check to finish
    task automatic wait_run();
        int n;
        n = 0;
        while (cpuReset !== 1'b0 && n < 300) begin @(posedge core_clk); #1 n++; end
        if (n >= 300) begin failures++; $display("MISMATCH run state expected 0 seen 1"); end
    endtask

    // counts cycles from a wake request to the stacking pulse
    task automatic wake_count(input int expd, input string name);
        int n;
        n = 0;
        @(posedge core_clk);
        irqReq <= 1'b1;
        do begin @(posedge core_clk); #1 n++; end while (stackStart !== 1'b1 && n < 200);
        @(posedge core_clk);
        irqReq <= 1'b0;
        check(name, n[15:0], expd[15:0]);
    endtask

    task automatic set_src(input int i, input logic v);
        case (i)
            0: watchdogTimeout <= v;
            1: badOpcode <= v;
            2: begin opcodeFetch <= v; unmappedAccess <= v; end
            3: begin monitorEntry <= v; vectorsErased <= v; irqPinHigh <= v; end
            4: lowVoltage <= v;
            5: extLow <= v;
            default: begin watchdogTimeout <= v; lowVoltage <= v; end
        endcase
    endtask

    initial begin
        #80000;
        failures++;
        summarize();
    end

    initial begin
        static sib_byte_t srcExp [7] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h40, 8'h22};
        int tickWait;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 check("pin pulled low", {15'h0, rstPinIn}, 16'h0000);
        wait_run();
        reg_read(16'hfe01, 8'h80, "power-on flags");
        reg_read(16'hfe01, 8'h00, "flags after read");
        reg_read(16'hfe03, 8'h00, "clear enable reset");
        reg_read(16'hfe02, 8'h00, "unmapped read");
        check("watchdog on", {15'h0, watchdogEnable}, 16'h0001);
        @(posedge core_clk);
        watchdogDisable <= 1'b1;
        #1 check("watchdog off", {15'h0, watchdogEnable}, 16'h0000);
        // break with clearing enabled, then protected
        reg_write(16'hfe03, 8'h80);
        reg_read(16'hfe03, 8'h80, "clear enable rw");
        @(posedge core_clk);
        breakReq <= 1'b1;
        @(posedge core_clk);
        breakReq <= 1'b0;
        #1 check("break vector", {15'h0, forceSwi}, 16'h0001);
        @(posedge core_clk);
        #1 check("break clear open", {14'h0, inBreak, flagClearAllow}, 16'h0003);
        reg_write(16'hfe03, 8'h00);
        #1 check("break protect", {14'h0, inBreak, flagClearAllow}, 16'h0002);
        @(posedge core_clk);
        breakDone <= 1'b1;
        @(posedge core_clk);
        breakDone <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check("break left", {14'h0, inBreak, flagClearAllow}, 16'h0001);
        // wait entry and interrupt wake
        @(posedge core_clk);
        waitInstr <= 1'b1;
        @(posedge core_clk);
        waitInstr <= 1'b0;
        #1 check("wait entry", {13'h0, clearIMask, cpuClkEn, periphClkEn}, 16'h0005);
        wake_count(1, "wait wake");
        // wait exited by break sets wait exit flag
        @(posedge core_clk);
        waitInstr <= 1'b1;
        @(posedge core_clk);
        waitInstr <= 1'b0;
        breakReq <= 1'b1;
        @(posedge core_clk);
        breakReq <= 1'b0;
        #1 check("wait break", {15'h0, forceSwi}, 16'h0001);
        reg_read(16'hfe00, 8'h02, "wait exit flag");
        reg_write(16'hfe00, 8'h00);
        reg_read(16'hfe00, 8'h00, "wait exit cleared");
        @(posedge core_clk);
        breakDone <= 1'b1;
        @(posedge core_clk);
        breakDone <= 1'b0;
        // stop with short then long recovery
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            stopInstr <= 1'b1;
            shortStopRecovery <= (k == 0);
            oscRunInStop <= (k == 1);
            @(posedge core_clk);
            stopInstr <= 1'b0;
            #1 check("stop entry", {12'h0, clearIMask, cpuClkEn, periphClkEn, crystalClkEn},
                     k == 0 ? 16'h0008 : 16'h0009);
            repeat (3) @(posedge core_clk);
            wake_count(k == 0 ? 33 : 65, "stop recovery");
        end
        #1 check("stacking count", {8'h0, stackCount}, 16'h0003);
        // prescaler overflow must still clock the watchdog in wait
        @(posedge core_clk);
        watchdogDisable <= 1'b0;
        waitInstr <= 1'b1;
        @(posedge core_clk);
        waitInstr <= 1'b0;
        tickWait = 0;
        while (watchdogTick !== 1'b1 && tickWait < 4200) begin @(posedge core_clk); #1 tickWait++; end
        check("watchdog tick", {15'h0, watchdogTick}, 16'h0001);
        wake_count(1, "watchdog wake");
        // data access to unmapped space does not reset
        @(posedge core_clk);
        unmappedAccess <= 1'b1;
        @(posedge core_clk);
        unmappedAccess <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 check("data fetch no reset", {15'h0, cpuReset}, 16'h0000);
        reg_read(16'hfe01, 8'h00, "no source flag");
        // every source, then two at once with no ranking
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            set_src(i, 1'b1);
            @(posedge core_clk);
            set_src(i, 1'b0);
            #1 check("source reset", {14'h0, cpuReset, rstPinOe}, 16'h0003);
            wait_run();
            reg_read(16'hfe01, srcExp[i], "source flag");
        end
        check("vector count", {8'h0, swiCount}, 16'h0002);
        summarize();
    end
endmodule
`default_nettype wire
